// ==== include/ras_params.svh ====
// Constants for the return address stack
`ifndef RAS_PARAMS_SVH
`define RAS_PARAMS_SVH
`define RAS_ADDR_W 12
`define RAS_IDX_W 4
`define RAS_SLOTS 5
`define RAS_IDX_EMPTY 4'h5
`define RAS_IDX_ONE 4'h1
`define RAS_PAGE_BIT 11
`define RAS_ADDR_ZERO 12'h000
`define RAS_WORD_ZERO 16'h0000
`endif

// ==== include/ras_pkg.sv ====
// Types for the return address stack
`include "ras_params.svh"
package ras_pkg;
  typedef enum logic [3:0] {
    OP_NONE, OP_CALL, OP_INT_ACK, OP_RET, OP_RET_SKIP, OP_INT_RET,
    OP_TABLE_FETCH, OP_PUSH_AR, OP_POP_AR, OP_IDX_WRITE
  } stack_op_t;
  typedef struct packed {
    stack_op_t op;
    logic [`RAS_ADDR_W-1:0] ret_addr;
    logic [`RAS_ADDR_W-1:0] table_addr_reg;
    logic [`RAS_IDX_W-1:0] idx_wdata;
  } stack_req_t;
endpackage

// ==== hdl/ras_slots.sv ====
// Storage slots of the return address stack
`timescale 1ns/10ps
`include "ras_params.svh"
module ras_slots (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [`RAS_IDX_W-1:0] wr_idx,
  input wire logic [`RAS_ADDR_W-1:0] wr_data,
  input wire logic [`RAS_IDX_W-1:0] rd_idx,
  output logic [`RAS_ADDR_W-1:0] rd_data
);
  logic [`RAS_ADDR_W-1:0] slot_q [`RAS_SLOTS];
  // ----------------------------------------------------------------
  // Slot array
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `RAS_SLOTS; g++) begin : gen_slot
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          slot_q[g] <= `RAS_ADDR_ZERO;
        end else if (wr_en && wr_idx == (`RAS_IDX_W)'(g)) begin
          slot_q[g] <= wr_data;
        end
      end
    end
  endgenerate
  // Index five and above have no storage; reads give zero (undefined)
  always_comb begin
    if (rd_idx < `RAS_SLOTS) begin
      rd_data = slot_q[rd_idx[2:0]];
    end else begin
      rd_data = `RAS_ADDR_ZERO;
    end
  end
endmodule

// ==== hdl/return_address_stack.sv ====
// Return address stack with 4-bit index and program counter
//
// Contract
// - Five 12-bit return slots indexed 0..4; index 5 has no storage.
// - Stack index is a 4-bit counter selecting the slot.
// - Software reads and writes the stack index directly.
// - Call: decrement index, then store return address at new index.
// - Returns load program counter from slot, then increment index.
// - Interrupt acknowledge: decrement index, store interrupted address.
// - Table fetch pushes, reads program word, restores counter, pops.
// - Push address register: decrement, store address register in slot.
// - Pop address register: load it from slot, then increment.
// - Depth is five; reading slot at index 5 gives undefined.
// - Program counter is 12 bits; its top bit selects the page.
`timescale 1ns/10ps
`include "ras_params.svh"
module return_address_stack (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_stop_reset,
  input wire logic chip_enable_reset,
  input wire ras_pkg::stack_req_t req,
  input wire logic [15:0] prog_word,
  output logic [`RAS_IDX_W-1:0] stack_index,
  output logic [`RAS_ADDR_W-1:0] pc,
  output logic pc_load,
  output logic pc_page,
  output logic [`RAS_ADDR_W-1:0] table_addr_reg,
  output logic table_addr_load,
  output logic [`RAS_ADDR_W-1:0] prog_addr,
  output logic [15:0] table_read_buffer,
  output logic table_busy
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TF_IDLE, TF_FETCH, TF_RESTORE} tf_state_t;
  tf_state_t tf_q;
  logic [`RAS_IDX_W-1:0] stack_index_q;
  logic [`RAS_IDX_W-1:0] dec_idx;
  logic [`RAS_IDX_W-1:0] inc_idx;
  logic wr_en;
  logic [`RAS_ADDR_W-1:0] wr_data;
  logic [`RAS_ADDR_W-1:0] rd_data;
  logic soft_reset;
  logic is_push;
  logic is_pop;

  assign soft_reset = clk_stop_reset | chip_enable_reset;
  assign dec_idx = stack_index_q - `RAS_IDX_ONE;
  assign inc_idx = stack_index_q + `RAS_IDX_ONE;
  assign is_push = tf_q == TF_IDLE &&
    (req.op == ras_pkg::OP_CALL || req.op == ras_pkg::OP_INT_ACK ||
     req.op == ras_pkg::OP_TABLE_FETCH || req.op == ras_pkg::OP_PUSH_AR);
  assign is_pop = tf_q == TF_IDLE &&
    (req.op == ras_pkg::OP_RET || req.op == ras_pkg::OP_RET_SKIP ||
     req.op == ras_pkg::OP_INT_RET || req.op == ras_pkg::OP_POP_AR);

  // ----------------------------------------------------------------
  // Slot write path: pushes store at the decremented index
  // ----------------------------------------------------------------
  assign wr_en = is_push;
  always_comb begin
    if (req.op == ras_pkg::OP_PUSH_AR) begin
      wr_data = req.table_addr_reg;
    end else begin
      wr_data = req.ret_addr;
    end
  end

  ras_slots u_slots (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(wr_en),
    .wr_idx(dec_idx),
    .wr_data(wr_data),
    .rd_idx(stack_index_q),
    .rd_data(rd_data)
  );

  // ----------------------------------------------------------------
  // Stack index
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_index_q <= `RAS_IDX_EMPTY;
    end else if (soft_reset) begin
      stack_index_q <= `RAS_IDX_EMPTY;
    end else if (tf_q == TF_IDLE && req.op == ras_pkg::OP_IDX_WRITE) begin
      stack_index_q <= req.idx_wdata;
    end else if (is_push) begin
      stack_index_q <= dec_idx;
    end else if (is_pop || tf_q == TF_RESTORE) begin
      stack_index_q <= inc_idx;
    end
  end
  assign stack_index = stack_index_q;

  // ----------------------------------------------------------------
  // Table fetch sequence
  // ----------------------------------------------------------------
  // Two extra cycles so the pushed slot is written before it is read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tf_q <= TF_IDLE;
    end else if (soft_reset) begin
      tf_q <= TF_IDLE;
    end else begin
      unique case (tf_q)
        TF_IDLE: begin
          if (req.op == ras_pkg::OP_TABLE_FETCH) begin
            tf_q <= TF_FETCH;
          end
        end
        TF_FETCH: begin
          tf_q <= TF_RESTORE;
        end
        TF_RESTORE: begin
          tf_q <= TF_IDLE;
        end
        default: begin
          tf_q <= TF_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_addr <= `RAS_ADDR_ZERO;
      table_read_buffer <= `RAS_WORD_ZERO;
      table_busy <= 1'b0;
    end else begin
      table_busy <= (tf_q == TF_IDLE && !soft_reset &&
                     req.op == ras_pkg::OP_TABLE_FETCH) ||
                    (tf_q == TF_FETCH && !soft_reset);
      if (tf_q == TF_IDLE && req.op == ras_pkg::OP_TABLE_FETCH) begin
        prog_addr <= req.table_addr_reg;
      end
      if (tf_q == TF_FETCH) begin
        table_read_buffer <= prog_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Program counter and address register restore
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc <= `RAS_ADDR_ZERO;
      pc_page <= 1'b0;
      pc_load <= 1'b0;
    end else if (soft_reset) begin
      pc <= `RAS_ADDR_ZERO;
      pc_page <= 1'b0;
      pc_load <= 1'b0;
    end else if ((is_pop && req.op != ras_pkg::OP_POP_AR) ||
                 tf_q == TF_RESTORE) begin
      pc <= rd_data;
      pc_page <= rd_data[`RAS_PAGE_BIT];
      pc_load <= 1'b1;
    end else begin
      pc_load <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      table_addr_reg <= `RAS_ADDR_ZERO;
      table_addr_load <= 1'b0;
    end else begin
      table_addr_load <= is_pop && req.op == ras_pkg::OP_POP_AR && !soft_reset;
      if (is_pop && req.op == ras_pkg::OP_POP_AR) begin
        table_addr_reg <= rd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_push_decrements: assert property (@(posedge clk) disable iff (!rst_n)
    is_push && !soft_reset |=>
    stack_index_q == $past(stack_index_q) - `RAS_IDX_ONE)
    else $error("push did not decrement index");
  a_pop_increments: assert property (@(posedge clk) disable iff (!rst_n)
    is_pop && !soft_reset |=>
    stack_index_q == $past(stack_index_q) + `RAS_IDX_ONE)
    else $error("pop did not increment index");
  a_soft_reset_empty: assert property (@(posedge clk) disable iff (!rst_n)
    soft_reset |=> stack_index_q == `RAS_IDX_EMPTY)
    else $error("index not empty after reset");
  a_call_ret_pair: assert property (@(posedge clk) disable iff (!rst_n)
    (req.op == ras_pkg::OP_CALL && tf_q == TF_IDLE && !soft_reset &&
     stack_index_q inside {[4'h1:4'h5]}) ##1
    (req.op == ras_pkg::OP_RET && !soft_reset) |=>
    pc_load && pc == $past(req.ret_addr, 2))
    else $error("return did not restore call address");
  a_pushar_popar: assert property (@(posedge clk) disable iff (!rst_n)
    (req.op == ras_pkg::OP_PUSH_AR && tf_q == TF_IDLE && !soft_reset &&
     stack_index_q inside {[4'h1:4'h5]}) ##1
    (req.op == ras_pkg::OP_POP_AR && !soft_reset) |=>
    table_addr_load && table_addr_reg == $past(req.table_addr_reg, 2))
    else $error("pop did not return pushed address");
  a_table_restore: assert property (@(posedge clk) disable iff (!rst_n)
    (req.op == ras_pkg::OP_TABLE_FETCH && tf_q == TF_IDLE && !soft_reset &&
     stack_index_q inside {[4'h1:4'h5]}) ##1 !soft_reset ##1 !soft_reset
    |=> pc_load && pc == $past(req.ret_addr, 3) &&
    stack_index_q == $past(stack_index_q, 3))
    else $error("table fetch did not restore counter");
  a_table_buffer: assert property (@(posedge clk) disable iff (!rst_n)
    tf_q == TF_FETCH |=> table_read_buffer == $past(prog_word))
    else $error("table word not captured");
  a_idx_write: assert property (@(posedge clk) disable iff (!rst_n)
    tf_q == TF_IDLE && !soft_reset && req.op == ras_pkg::OP_IDX_WRITE
    |=> stack_index == $past(req.idx_wdata))
    else $error("index write lost");
  a_page_bit: assert property (@(posedge clk) disable iff (!rst_n)
    pc_load |-> pc_page == pc[`RAS_PAGE_BIT])
    else $error("page bit mismatch");
  c_call: cover property (@(posedge clk) disable iff (!rst_n)
    is_push && req.op == ras_pkg::OP_CALL);
  c_int_return: cover property (@(posedge clk) disable iff (!rst_n)
    is_pop && req.op == ras_pkg::OP_INT_RET);
  c_table: cover property (@(posedge clk) disable iff (!rst_n)
    tf_q == TF_RESTORE);
  c_full: cover property (@(posedge clk) disable iff (!rst_n)
    stack_index_q == 4'h0);
endmodule

// ==== bench/prog_mem_model.sv ====
// Program memory model that answers table fetch reads
`timescale 1ns/10ps
module prog_mem_model (
  input wire logic [11:0] addr,
  output logic [15:0] word
);
  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Word follows its address at once: the fetch samples it one edge after
  // the address register loads, so a registered read would be one too late
  always_comb begin
    word = {addr[3:0], addr};
  end
endmodule

// ==== bench/tb_return_address_stack.sv ====
// Self-checking testbench of the return address stack
`timescale 1ns/10ps
module tb_return_address_stack;
  typedef struct packed {
    ras_pkg::stack_op_t op;
    logic [11:0] addr;
    logic [11:0] ar;
    logic [3:0] idx;
    logic [1:0] kind;
    logic [3:0] exp_idx;
    logic [11:0] exp_val;
  } row_t;
  logic clk, rst_n, clk_stop_reset, chip_enable_reset, pc_load, pc_page;
  logic table_addr_load, table_busy;
  ras_pkg::stack_req_t req;
  logic [15:0] prog_word, table_read_buffer;
  logic [3:0] stack_index;
  logic [11:0] pc, table_addr_reg, prog_addr;
  int num_errors = 0;
  int compares = 0;
  row_t rows [11];
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  return_address_stack u_return_address_stack (.clk(clk), .rst_n(rst_n),
    .clk_stop_reset(clk_stop_reset), .chip_enable_reset(chip_enable_reset),
    .req(req), .prog_word(prog_word), .stack_index(stack_index), .pc(pc),
    .pc_load(pc_load), .pc_page(pc_page), .table_addr_reg(table_addr_reg),
    .table_addr_load(table_addr_load), .prog_addr(prog_addr),
    .table_read_buffer(table_read_buffer), .table_busy(table_busy));
  prog_mem_model u_prog_mem_model (.addr(prog_addr), .word(prog_word));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic final_report();
    if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Entered at a falling edge; op stands until the next request replaces
  // it or the caller idles it, so req changes only at falling edges
  task automatic send(input row_t r);
    req = '{r.op, r.addr, r.ar, r.idx};
    @(negedge clk);
  endtask
  task automatic wait_load(input logic [1:0] kind);
    int n;
    n = 0;
    while ((kind == 2'd2 ? table_addr_load : pc_load) !== 1'b1) begin
      n++;
      if (n > 5) begin
        num_errors++;
        $display("[ERR] %0t no load pulse", $time);
        final_report();
      end
      @(negedge clk);
    end
  endtask
  task automatic apply(input row_t r);
    send(r);
    if (r.kind != 2'd0) begin
      req.op = ras_pkg::OP_NONE;
      wait_load(r.kind);
    end
    chk(16'(stack_index), 16'(r.exp_idx), "index");
    if (r.kind == 2'd2) chk(16'(table_addr_reg), 16'(r.exp_val), "ar");
    else if (r.kind != 2'd0) begin
      chk(16'(pc), 16'(r.exp_val), "pc");
      chk(16'(pc_page), 16'(r.exp_val[11]), "page");
    end
    if (r.kind == 2'd3) begin
      chk(16'(prog_addr), 16'(r.ar), "fetch addr");
      chk(table_read_buffer, {r.ar[3:0], r.ar}, "buffer");
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    clk_stop_reset = 1'b0;
    chip_enable_reset = 1'b0;
    req = '0;
    rows[0] = '{ras_pkg::OP_CALL, 12'h123, 12'h000, 4'h0, 2'd0, 4'h4, 12'h000};
    rows[1] = '{ras_pkg::OP_CALL, 12'h8A5, 12'h000, 4'h0, 2'd0, 4'h3, 12'h000};
    rows[2] = '{ras_pkg::OP_RET, 12'h000, 12'h000, 4'h0, 2'd1, 4'h4, 12'h8A5};
    rows[3] = '{ras_pkg::OP_INT_ACK, 12'h456, 12'h000, 4'h0, 2'd0, 4'h3, 12'h000};
    rows[4] = '{ras_pkg::OP_INT_RET, 12'h000, 12'h000, 4'h0, 2'd1, 4'h4, 12'h456};
    rows[5] = '{ras_pkg::OP_PUSH_AR, 12'h000, 12'h7E1, 4'h0, 2'd0, 4'h3, 12'h000};
    rows[6] = '{ras_pkg::OP_POP_AR, 12'h000, 12'h000, 4'h0, 2'd2, 4'h4, 12'h7E1};
    rows[7] = '{ras_pkg::OP_TABLE_FETCH, 12'h9C0, 12'h3B7, 4'h0, 2'd3, 4'h4, 12'h9C0};
    rows[8] = '{ras_pkg::OP_RET_SKIP, 12'h000, 12'h000, 4'h0, 2'd1, 4'h5, 12'h123};
    rows[9] = '{ras_pkg::OP_IDX_WRITE, 12'h000, 12'h000, 4'h2, 2'd0, 4'h2, 12'h000};
    rows[10] = '{ras_pkg::OP_POP_AR, 12'h000, 12'h000, 4'h0, 2'd2, 4'h3, 12'h000};
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    chk(16'(stack_index), 16'h0005, "reset index");
    chk(16'(pc), 16'h0000, "reset pc");
    foreach (rows[i]) apply(rows[i]);
    // Slot 5 has no storage and reads back as zero
    apply('{ras_pkg::OP_IDX_WRITE, 12'h000, 12'h000, 4'h5, 2'd0, 4'h5, 12'h000});
    apply('{ras_pkg::OP_POP_AR, 12'h000, 12'h000, 4'h0, 2'd2, 4'h6, 12'h000});
    apply('{ras_pkg::OP_IDX_WRITE, 12'h000, 12'h000, 4'h5, 2'd0, 4'h5, 12'h000});
    // Full depth of five, unwound in reverse order
    for (int i = 0; i < 5; i++)
      apply('{ras_pkg::OP_CALL, 12'(12'h100 + i), 12'h000, 4'h0, 2'd0, 4'(4 - i), 12'h000});
    for (int i = 4; i >= 0; i--)
      apply('{ras_pkg::OP_RET, 12'h000, 12'h000, 4'h0, 2'd1, 4'(5 - i), 12'(12'h100 + i)});
    // A call issued while a table fetch runs is dropped
    req = '{ras_pkg::OP_TABLE_FETCH, 12'h2D4, 12'h0F0, 4'h0};
    @(negedge clk);
    chk(16'(table_busy), 16'h0001, "busy");
    req = '{ras_pkg::OP_CALL, 12'h555, 12'h000, 4'h0};
    @(negedge clk);
    req.op = ras_pkg::OP_NONE;
    wait_load(2'd1);
    chk(16'(pc), 16'h02D4, "fetch pc");
    chk(16'(stack_index), 16'h0005, "fetch index");
    chk(16'(table_busy), 16'h0000, "busy end");
    // Clock-stop and chip-enable resets each empty the stack
    for (int k = 0; k < 2; k++) begin
      apply('{ras_pkg::OP_CALL, 12'h321, 12'h000, 4'h0, 2'd0, 4'h4, 12'h000});
      req.op = ras_pkg::OP_NONE;
      if (k == 0) clk_stop_reset = 1'b1;
      else chip_enable_reset = 1'b1;
      @(negedge clk);
      clk_stop_reset = 1'b0;
      chip_enable_reset = 1'b0;
      chk(16'(stack_index), 16'h0005, "soft reset index");
      chk(16'(pc), 16'h0000, "soft reset pc");
    end
    // Power-on reset in mid-run acts without a clock edge
    apply('{ras_pkg::OP_CALL, 12'h777, 12'h000, 4'h0, 2'd0, 4'h4, 12'h000});
    req.op = ras_pkg::OP_NONE;
    #1 rst_n = 1'b0;
    #0.5 chk(16'(stack_index), 16'h0005, "async reset");
    @(negedge clk);
    rst_n = 1'b1;
    chk(16'(stack_index), 16'h0005, "after release");
    apply('{ras_pkg::OP_CALL, 12'h246, 12'h000, 4'h0, 2'd0, 4'h4,
            12'h000});
    req.op = ras_pkg::OP_NONE;
    apply('{ras_pkg::OP_RET, 12'h000, 12'h000, 4'h0, 2'd1, 4'h5,
            12'h246});
    final_report();
  end
endmodule
